/* File: include/mdfp_pkg.sv */
// Purpose: constants and types of the motor driver fault protection
// Assumes: 125 MHz clock, APB register access, 32-bit data
// Notes: times are in ns, cycle counts are derived from them
package mdfp_pkg;

   // Clock and times
   localparam int CLK_NS        = 8;
   localparam int OCP_FILTER_NS = 3000;
   localparam int RETRY_NS      = 4000000;
   localparam int OL_SHORT_NS   = 200000;
   localparam int OL_LONG_NS    = 800000;
   localparam int OCP_FILTER_CYC = (OCP_FILTER_NS + CLK_NS - 1) / CLK_NS;
   localparam int RETRY_CYC      = (RETRY_NS + CLK_NS - 1) / CLK_NS;
   localparam int OL_SHORT_CYC   = (OL_SHORT_NS + CLK_NS - 1) / CLK_NS;
   localparam int OL_LONG_CYC    = (OL_LONG_NS + CLK_NS - 1) / CLK_NS;
   localparam int OCP_FILT_W     = 9;
   localparam int CNT_W          = 24;

   // Register map
   localparam int         APB_AW     = 8;
   localparam logic [7:0] OFF_CONFIG = 8'h00;
   localparam logic [7:0] OFF_CTRL   = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;

   // Config fields and reset values
   localparam int         CFG_OCP_LSB  = 0;
   localparam int         CFG_MODE_LSB = 2;
   localparam int         CFG_PCHK_BIT = 4;
   localparam int         CFG_OLDY_BIT = 5;
   localparam logic [1:0] OCP_LATCH    = 2'h0;
   localparam logic [1:0] OCP_RETRY    = 2'h1;
   localparam logic [1:0] OCP_REPORT   = 2'h2;
   localparam logic [1:0] OCP_OFF      = 2'h3;
   localparam logic [1:0] MODE_INDEP   = 2'h2;
   localparam logic [1:0] OCP_MODE_RST = OCP_LATCH;
   localparam logic [1:0] MODE_RST     = 2'h0;

   // Control and status fields
   localparam int CTL_CLR_BIT  = 0;
   localparam int CTL_REQ_BIT  = 1;
   localparam int STS_FAULT    = 0;
   localparam int STS_UV       = 1;
   localparam int STS_PUMP     = 2;
   localparam int STS_OCP      = 3;
   localparam int STS_FET_LSB  = 4;
   localparam int STS_OL_LSB   = 8;
   localparam int STS_TEST     = 10;

   typedef enum logic [1:0] {
      OL_IDLE,
      OL_PULLUP,
      OL_PULLDOWN
   } mdfp_ol_state_t;

endpackage : mdfp_pkg

/* File: src/mdfp_sync.sv */
// Purpose: two-flop synchroniser for a vector of pin inputs
// Assumes: bits are independent levels
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module mdfp_sync #(
   parameter int WIDTH = 1
)(
   input  wire logic             clock,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] held;
   } mdfp_sync_t;

   mdfp_sync_t st;
   mdfp_sync_t next_st;

   // Shift the pin levels one stage on
   always_comb begin
      next_st.meta = d;
      next_st.held = st.meta;
   end

   // Two stages, cleared on reset
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Only the second stage leaves the module
   assign q = st.held;

endmodule : mdfp_sync

/* File: src/mdfp_top.sv */
// Purpose: fault protection and open-load test of an H-bridge driver
// Assumes: analog comparators and pins arrive asynchronously
// Notes: FET order is high1, low1, high2, low2
`timescale 1ns/1ps
module mdfp_top
   import mdfp_pkg::*;
#(
   parameter int RETRY_CYCLES    = RETRY_CYC,
   parameter int OL_SHORT_CYCLES = OL_SHORT_CYC,
   parameter int OL_LONG_CYCLES  = OL_LONG_CYC,
   parameter bit PIN_VARIANT     = 1'b0
)(
   input  wire logic              clock,
   input  wire logic              reset,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [APB_AW-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              supply_undervoltage_lock,
   input  wire logic              pump_undervoltage,
   input  wire logic [3:0]        fet_overcurrent,
   input  wire logic [1:0]        pullup_open_comparator,
   input  wire logic [1:0]        pulldown_open_comparator,
   input  wire logic              disable_pin,
   input  wire logic              sleep_control_low,
   input  wire logic              open_load_disable_pin,
   input  wire logic              motor_energized,
   output logic      [1:0]        bridge_enable,
   output logic                   pump_enable,
   output logic      [1:0]        pullup_enable,
   output logic      [1:0]        pulldown_enable,
   output logic                   fault_indicator_low_out,
   output logic                   fault_indicator_low_oe
);

   typedef struct packed {
      logic                       pready;
      logic                       pslverr;
      logic [31:0]                prdata;
      logic [1:0]                 ocp_mode;
      logic [1:0]                 bridge_mode;
      logic                       pump_uv_check_off;
      logic                       open_load_long_delay;
      logic                       open_load_test_request;
      logic                       ol_pending;
      logic                       awake_d;
      logic                       uv_flag;
      logic                       pump_flag;
      logic                       ocp_flag;
      logic [3:0]                 fet_ocp_flag;
      logic [1:0]                 open_load_flag;
      logic [3:0][OCP_FILT_W-1:0] ocp_filt;
      logic [1:0]                 ocp_hold;
      logic [1:0][CNT_W-1:0]      retry_cnt;
      mdfp_ol_state_t             ol_state;
      logic [CNT_W-1:0]           ol_cnt;
      logic [1:0]                 pu_seen;
      logic [1:0]                 bridge_enable;
      logic                       pump_enable;
      logic [1:0]                 pullup_enable;
      logic [1:0]                 pulldown_enable;
      logic                       fault_out;
      logic                       fault_oe;
   } mdfp_state_t;

   mdfp_state_t      s;
   mdfp_state_t      next_s;
   logic [13:0]      sync_q;
   logic             uv_s;
   logic             pump_s;
   logic [3:0]       ocp_s;
   logic [1:0]       pu_s;
   logic [1:0]       pd_s;
   logic             dis_s;
   logic             awake_s;
   logic             olskip_s;
   logic             energ_s;
   logic             acc;
   logic             hit_cfg;
   logic             hit_ctl;
   logic             hit_sts;
   logic             wr_done;
   logic             wake;
   logic             clr;
   logic             req_wr;
   logic             pump_act;
   logic             indep;
   logic             ocp_on;
   logic [3:0]       ocp_evt;
   logic [1:0]       hb_evt;
   logic [1:0]       hb_cond;
   logic [1:0]       hold_eff;
   logic             ocp_ind;
   logic             abort;
   logic             start_ok;
   logic [1:0]       ol_set;
   logic [CNT_W-1:0] step;
   logic             drive_ok;
   logic [31:0]      rdata;

   // Pin and comparator synchroniser
   mdfp_sync #(
      .WIDTH (14)
   ) u_sync (
      .clock (clock),
      .reset (reset),
      .d     ({supply_undervoltage_lock, pump_undervoltage,
               fet_overcurrent, pullup_open_comparator,
               pulldown_open_comparator, disable_pin,
               sleep_control_low, open_load_disable_pin,
               motor_energized}),
      .q     (sync_q)
   );

   // Synchronised levels
   assign {uv_s, pump_s, ocp_s, pu_s, pd_s, dis_s, awake_s, olskip_s,
           energ_s} = sync_q;

   // Next-state logic
   always_comb begin
      next_s   = s;
      rdata    = '0;
      ocp_evt  = '0;
      ol_set   = '0;
      acc      = psel & penable;
      hit_cfg  = (paddr == OFF_CONFIG);
      hit_ctl  = (paddr == OFF_CTRL);
      hit_sts  = (paddr == OFF_STATUS);
      wr_done  = acc & s.pready & pwrite & ~s.pslverr;
      wake     = awake_s & ~s.awake_d;
      next_s.awake_d = awake_s;

      // APB slave, one wait state
      next_s.pready  = acc & ~s.pready;
      next_s.pslverr = acc & ~s.pready & ~(hit_cfg | hit_ctl | hit_sts);
      rdata[CFG_OCP_LSB +: 2]  = hit_cfg ? s.ocp_mode : 2'h0;
      rdata[CFG_MODE_LSB +: 2] = hit_cfg ? s.bridge_mode : 2'h0;
      rdata[CFG_PCHK_BIT] = hit_cfg & s.pump_uv_check_off;
      rdata[CFG_OLDY_BIT] = hit_cfg & s.open_load_long_delay;
      if (hit_ctl) begin
         rdata[CTL_REQ_BIT] = s.open_load_test_request;
      end
      if (hit_sts) begin
         rdata[STS_FAULT] = s.uv_flag | s.pump_flag | s.ocp_flag |
                            (|s.fet_ocp_flag) | (|s.open_load_flag) |
                            s.fault_oe;
         rdata[STS_UV]   = s.uv_flag;
         rdata[STS_PUMP] = s.pump_flag;
         rdata[STS_OCP]  = s.ocp_flag;
         rdata[STS_FET_LSB +: 4] = s.fet_ocp_flag;
         rdata[STS_OL_LSB +: 2]  = s.open_load_flag;
         rdata[STS_TEST] = (s.ol_state != OL_IDLE);
      end
      next_s.prdata = (acc & ~s.pready & ~pwrite) ? rdata : 32'h0;

      // Configuration writes
      if (wr_done & hit_cfg) begin
         next_s.ocp_mode    = pwdata[CFG_OCP_LSB +: 2];
         next_s.bridge_mode = pwdata[CFG_MODE_LSB +: 2];
         next_s.pump_uv_check_off    = pwdata[CFG_PCHK_BIT];
         next_s.open_load_long_delay = pwdata[CFG_OLDY_BIT];
      end
      clr    = (wr_done & hit_ctl & pwdata[CTL_CLR_BIT]) | wake;
      req_wr = wr_done & hit_ctl & pwdata[CTL_REQ_BIT];

      next_s.uv_flag = (s.uv_flag & ~(clr & ~uv_s)) | uv_s;
      pump_act = pump_s & ~s.pump_uv_check_off;
      next_s.pump_flag = (s.pump_flag & ~(clr & ~pump_act)) | pump_act;

      for (int f = 0; f < 4; f++) begin
         ocp_evt[f] = ocp_s[f] &
            (s.ocp_filt[f] == OCP_FILT_W'(OCP_FILTER_CYC - 1));
         if (!ocp_s[f]) begin
            next_s.ocp_filt[f] = '0;
         end else if (s.ocp_filt[f] != OCP_FILT_W'(OCP_FILTER_CYC)) begin
            next_s.ocp_filt[f] = s.ocp_filt[f] + 1'b1;
         end
      end

      indep   = (s.bridge_mode == MODE_INDEP);
      ocp_on  = (s.ocp_mode != OCP_OFF);
      hb_evt  = {ocp_evt[3] | ocp_evt[2], ocp_evt[1] | ocp_evt[0]};
      hb_cond = {ocp_s[3] | ocp_s[2], ocp_s[1] | ocp_s[0]};
      if (!indep) begin
         hb_evt  = {2{|ocp_evt}};
         hb_cond = {2{|ocp_s}};
      end
      if (!ocp_on) begin
         hb_evt = 2'h0;
      end

      next_s.ocp_flag = (s.ocp_flag & ~(clr & ~(|ocp_s))) | (|hb_evt);
      for (int f = 0; f < 4; f++) begin
         next_s.fet_ocp_flag[f] = (s.fet_ocp_flag[f] &
            ~(clr & ~ocp_s[f])) | (ocp_evt[f] & ocp_on);
      end

      // Shutdown hold per half-bridge
      for (int h = 0; h < 2; h++) begin
         if (hb_evt[h] && (s.ocp_mode == OCP_LATCH ||
                           s.ocp_mode == OCP_RETRY)) begin
            next_s.ocp_hold[h]  = 1'b1;
            next_s.retry_cnt[h] = CNT_W'(RETRY_CYCLES - 1);
         end else if (s.ocp_mode == OCP_RETRY) begin
            if (s.retry_cnt[h] != '0) begin
               next_s.retry_cnt[h] = s.retry_cnt[h] - 1'b1;
            end else if (!hb_cond[h]) begin
               next_s.ocp_hold[h] = 1'b0;
            end
         end else if (s.ocp_mode == OCP_LATCH) begin
            if (clr && !hb_cond[h]) begin
               next_s.ocp_hold[h] = 1'b0;
            end
         end else begin
            next_s.ocp_hold[h] = 1'b0;
         end
      end
      hold_eff = indep ? s.ocp_hold : {2{|s.ocp_hold}};
      ocp_ind  = (|s.ocp_hold) | ((s.ocp_mode == OCP_REPORT) & s.ocp_flag);

      // Open-load test sequencing
      step = s.open_load_long_delay ? CNT_W'(OL_LONG_CYCLES - 1)
                                    : CNT_W'(OL_SHORT_CYCLES - 1);
      abort = ~awake_s | energ_s | (~PIN_VARIANT & ~dis_s);
      start_ok = 1'b0;
      if (PIN_VARIANT) begin
         next_s.ol_pending = s.ol_pending | wake;
         if ((s.ol_pending | wake) && awake_s && s.ol_state == OL_IDLE) begin
            next_s.ol_pending = 1'b0;
            start_ok = ~olskip_s & ~energ_s;
         end
      end else begin
         start_ok = req_wr & awake_s & dis_s & ~energ_s &
                    (s.ol_state == OL_IDLE);
      end

      case (s.ol_state)
         OL_IDLE: begin
            if (start_ok) begin
               next_s.ol_state = OL_PULLUP;
               next_s.ol_cnt   = step;
               next_s.open_load_test_request = 1'b1;
            end
         end
         OL_PULLUP: begin
            if (abort) begin
               next_s.ol_state = OL_IDLE;
               next_s.open_load_test_request = 1'b0;
            end else if (s.ol_cnt == '0) begin
               next_s.pu_seen  = pu_s;
               next_s.ol_state = OL_PULLDOWN;
               next_s.ol_cnt   = step;
            end else begin
               next_s.ol_cnt = s.ol_cnt - 1'b1;
            end
         end
         OL_PULLDOWN: begin
            if (abort) begin
               next_s.ol_state = OL_IDLE;
               next_s.open_load_test_request = 1'b0;
            end else if (s.ol_cnt == '0) begin
               ol_set = s.pu_seen & pd_s;
               next_s.ol_state = OL_IDLE;
               next_s.open_load_test_request = 1'b0;
            end else begin
               next_s.ol_cnt = s.ol_cnt - 1'b1;
            end
         end
         default: begin
            next_s.ol_state = OL_IDLE;
         end
      endcase

      next_s.open_load_flag = (s.open_load_flag & ~{2{clr}}) | ol_set;

      next_s.fault_out = 1'b0;
      next_s.fault_oe  = awake_s & (uv_s | pump_act | ocp_ind |
                                    (|s.open_load_flag) | (|ol_set));
      drive_ok = awake_s & ~uv_s & ~pump_act & ~dis_s &
                 (s.ol_state == OL_IDLE) & (next_s.ol_state == OL_IDLE);
      next_s.bridge_enable = {2{drive_ok}} & ~hold_eff;
      next_s.pump_enable     = awake_s & ~uv_s;
      next_s.pullup_enable   = {2{next_s.ol_state == OL_PULLUP}};
      next_s.pulldown_enable = {2{next_s.ol_state == OL_PULLDOWN}};
   end

   // State register
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         s             <= '0;
         s.ocp_mode    <= OCP_MODE_RST;
         s.bridge_mode <= MODE_RST;
         s.ol_pending  <= 1'b1;
         s.ol_state    <= OL_IDLE;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from state
   assign prdata                  = s.prdata;
   assign pready                  = s.pready;
   assign pslverr                 = s.pslverr;
   assign bridge_enable           = s.bridge_enable;
   assign pump_enable             = s.pump_enable;
   assign pullup_enable           = s.pullup_enable;
   assign pulldown_enable         = s.pulldown_enable;
   assign fault_indicator_low_out = s.fault_out;
   assign fault_indicator_low_oe  = s.fault_oe;

endmodule : mdfp_top

/* File: test/mdfp_sva.sv */
// Purpose: port-level checks of the fault protection block
// Assumes: one clock, async high reset, serial variant
// Notes: config shadow follows completed APB writes
`timescale 1ns/1ps
module mdfp_sva
   import mdfp_pkg::*;
(
   input wire logic              clock,
   input wire logic              reset,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              supply_undervoltage_lock,
   input wire logic              pump_undervoltage,
   input wire logic              disable_pin,
   input wire logic              sleep_control_low,
   input wire logic              motor_energized,
   input wire logic [1:0]        bridge_enable,
   input wire logic              pump_enable,
   input wire logic [1:0]        pullup_enable,
   input wire logic [1:0]        pulldown_enable,
   input wire logic              fault_indicator_low_oe
);
   logic [5:0] cfg_q;
   logic       rd_ctl;
   logic       tst_on;

   // Read of control, and test running
   assign rd_ctl = psel && penable && pready && !pwrite && paddr == OFF_CTRL;
   assign tst_on = pullup_enable != 2'h0 || pulldown_enable != 2'h0;

   // Shadow of the config register
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         cfg_q <= 6'h00;
      end else if (psel && penable && pready && pwrite &&
                   paddr == OFF_CONFIG) begin
         cfg_q <= pwdata[5:0];
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   property p_uv_off;
      (supply_undervoltage_lock && sleep_control_low)[*4] |=>
         bridge_enable == 2'h0 && !pump_enable && fault_indicator_low_oe;
   endproperty
   property p_pump;
      (pump_undervoltage && !supply_undervoltage_lock && sleep_control_low
       && !cfg_q[CFG_PCHK_BIT])[*4] |=>
         bridge_enable == 2'h0 && pump_enable && fault_indicator_low_oe;
   endproperty
   property p_tst_off;
      tst_on |-> bridge_enable == 2'h0;
   endproperty
   property p_order;
      $rose(pulldown_enable[0]) |->
         $past(pullup_enable[0], 1) || $past(pullup_enable[0], 2);
   endproperty
   property p_req_rd;
      rd_ctl && tst_on && $past(tst_on) |-> prdata[CTL_REQ_BIT];
   endproperty
   property p_energ;
      motor_energized[*4] |=> pullup_enable == 2'h0 && !pulldown_enable[0];
   endproperty
   property p_abort;
      (!disable_pin)[*4] |=> !tst_on;
   endproperty
   property p_sleep;
      (!sleep_control_low)[*4] |=>
         bridge_enable == 2'h0 && !fault_indicator_low_oe;
   endproperty

   a_uv_off: assert property (p_uv_off)
      else $error("bridge or pump on in supply lockout");
   a_pump: assert property (p_pump)
      else $error("bridge on or pump off in pump lockout");
   a_tst_off: assert property (p_tst_off)
      else $error("bridge on during load test");
   a_order: assert property (p_order)
      else $error("pull-down step without pull-up step");
   a_req_rd: assert property (p_req_rd)
      else $error("request bit low while test runs");
   a_energ: assert property (p_energ)
      else $error("load test while motor energized");
   a_abort: assert property (p_abort)
      else $error("load test kept with disable low");
   a_sleep: assert property (p_sleep)
      else $error("bridge or indicator active in sleep");

   c_test: cover property ($rose(pulldown_enable[0]));
   c_uv: cover property ($rose(supply_undervoltage_lock));
   c_rd: cover property (rd_ctl && tst_on);
endmodule : mdfp_sva

bind mdfp_top mdfp_sva mdfp_sva_inst (
   .clock(clock), .reset(reset), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .supply_undervoltage_lock(supply_undervoltage_lock),
   .pump_undervoltage(pump_undervoltage), .disable_pin(disable_pin),
   .sleep_control_low(sleep_control_low),
   .motor_energized(motor_energized), .bridge_enable(bridge_enable),
   .pump_enable(pump_enable), .pullup_enable(pullup_enable),
   .pulldown_enable(pulldown_enable),
   .fault_indicator_low_oe(fault_indicator_low_oe)
);

/* File: test/mdfp_load_model.sv */
// Purpose: load on the two outputs as seen by the test sources
// Assumes: comparator follows its source at once
// Notes: a comparator with its source off reads low
`timescale 1ns/1ps
module mdfp_load_model (
   input  wire logic [1:0] pullup_enable,
   input  wire logic [1:0] pulldown_enable,
   input  wire logic [1:0] open_pu,
   input  wire logic [1:0] open_pd,
   output logic      [1:0] pullup_open_comparator,
   output logic      [1:0] pulldown_open_comparator
);
   assign pullup_open_comparator   = pullup_enable & open_pu;
   assign pulldown_open_comparator = pulldown_enable & open_pd;
endmodule : mdfp_load_model

/* File: test/mdfp_top_tb_top.sv */
// Purpose: directed tests of the fault protection block
// Assumes: short retry and test counts
// Notes: inputs change by NBA just after rising edges
`timescale 1ns/1ps
module mdfp_top_tb_top
   import mdfp_pkg::*;
;
   localparam int SHORT = 8;
   localparam int LONG  = 16;
   logic        clock, reset, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic        sup_lock, pump_lo, dis_pin, sleep_low, energ, err;
   logic [3:0]  fet_oc;
   logic [1:0]  pu_cmp, pd_cmp, open_pu, open_pd, bridge_en, pu_en, pd_en;
   logic        pump_en, flt_out, flt_oe;
   int          bad_count, total_checks, i, len_l, len_s;
   logic [31:0] cfg_t [5] = '{32'h8, 32'h9, 32'hA, 32'hB, 32'h0};
   logic [31:0] sts_t [5] = '{32'h19, 32'h19, 32'h19, 32'h0, 32'h19};
   logic [3:0]  on_t  [5] = '{4'hB, 4'hB, 4'hF, 4'hE, 4'h3};
   logic [3:0]  off_t [5] = '{4'hB, 4'hE, 4'hF, 4'hE, 4'h3};

   mdfp_top #(.RETRY_CYCLES(20), .OL_SHORT_CYCLES(SHORT),
      .OL_LONG_CYCLES(LONG), .PIN_VARIANT(1'b0)) mdfp_top_inst (
      .clock(clock), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr),
      .supply_undervoltage_lock(sup_lock), .pump_undervoltage(pump_lo),
      .fet_overcurrent(fet_oc), .pullup_open_comparator(pu_cmp),
      .pulldown_open_comparator(pd_cmp), .disable_pin(dis_pin),
      .sleep_control_low(sleep_low), .open_load_disable_pin(1'b0),
      .motor_energized(energ), .bridge_enable(bridge_en),
      .pump_enable(pump_en), .pullup_enable(pu_en),
      .pulldown_enable(pd_en), .fault_indicator_low_out(flt_out),
      .fault_indicator_low_oe(flt_oe));

   mdfp_load_model mdfp_load_model_inst (
      .pullup_enable(pu_en), .pulldown_enable(pd_en), .open_pu(open_pu),
      .open_pd(open_pd), .pullup_open_comparator(pu_cmp),
      .pulldown_open_comparator(pd_cmp));

   // Clock at 125 MHz
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : complete_run

   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_word

   // Pins as bridge, pump, indicator
   task automatic check_pins(input logic [3:0] exp);
      total_checks++;
      if ({bridge_en, pump_en, flt_oe} !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time,
                  {bridge_en, pump_en, flt_oe}, exp);
      end
   endtask : check_pins

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clock);
   endtask : wait_cyc

   // APB transfer, held until pready at an edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clock);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdv = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         bad_count++;
         complete_run();
      end
   endtask : apb

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check_word(rdv, exp);
   endtask : rd_chk

   // Open-load test run, cycles of both steps left after the two readbacks
   task automatic ol_run(input logic [31:0] cfg, output int len);
      apb(1'b1, OFF_CONFIG, cfg);
      dis_pin <= 1'b1;
      wait_cyc(4);
      apb(1'b1, OFF_CTRL, 32'h2);
      rd_chk(OFF_CTRL, 32'h2);
      rd_chk(OFF_STATUS, 32'h400);
      len = 0;
      while ((pu_en | pd_en) !== 2'h0 && len < 300) begin
         @(posedge clock);
         len++;
      end
      wait_cyc(4);
      rd_chk(OFF_CTRL, 32'h0);
      dis_pin <= 1'b0;
      wait_cyc(6);
      if (len >= 300) begin
         bad_count++;
         complete_run();
      end
   endtask : ol_run

   // Main sequence
   initial begin
      {reset, sleep_low} = 2'b10;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {sup_lock, pump_lo, dis_pin, energ, fet_oc} = '0;
      {open_pu, open_pd} = 4'h0;
      wait_cyc(8);
      reset     <= 1'b0;
      sleep_low <= 1'b1;
      wait_cyc(8);
      rd_chk(OFF_CONFIG, 32'h0);
      rd_chk(OFF_STATUS, 32'h0);
      apb(1'b0, 8'h0C, 32'h0);
      check_word({31'h0, err}, 32'h1);
      check_pins(4'hE);
      $display("test reset done");
      for (i = 0; i < 2; i++) begin
         {pump_lo, sup_lock} <= 2'h1 << i;
         wait_cyc(8);
         check_pins(i ? 4'h3 : 4'h1);
         rd_chk(OFF_STATUS, i ? 32'h5 : 32'h3);
         {pump_lo, sup_lock} <= 2'h0;
         wait_cyc(8);
         check_pins(4'hE);
         rd_chk(OFF_STATUS, i ? 32'h5 : 32'h3);
         apb(1'b1, OFF_CTRL, 32'h1);
         wait_cyc(4);
         rd_chk(OFF_STATUS, 32'h0);
      end
      apb(1'b1, OFF_CONFIG, 32'h10);
      pump_lo <= 1'b1;
      wait_cyc(8);
      check_pins(4'hE);
      rd_chk(OFF_STATUS, 32'h0);
      pump_lo <= 1'b0;
      apb(1'b1, OFF_CONFIG, 32'h0);
      $display("test lockout done");
      fet_oc <= 4'h1;
      wait_cyc(300);
      fet_oc <= 4'h0;
      rd_chk(OFF_STATUS, 32'h0);
      for (i = 0; i < 5; i++) begin
         apb(1'b1, OFF_CONFIG, cfg_t[i]);
         fet_oc <= 4'h1;
         wait_cyc(400);
         check_pins(on_t[i]);
         rd_chk(OFF_STATUS, sts_t[i]);
         fet_oc <= 4'h0;
         wait_cyc(40);
         check_pins(off_t[i]);
         apb(1'b1, OFF_CTRL, 32'h1);
         wait_cyc(6);
         check_pins(4'hE);
      end
      $display("test overcurrent done");
      open_pu <= 2'h3;
      open_pd <= 2'h1;
      ol_run(32'h20, len_l);
      rd_chk(OFF_STATUS, 32'h101);
      check_pins(4'hF);
      check_word({31'h0, flt_out}, 32'h0);
      sleep_low <= 1'b0;
      wait_cyc(8);
      check_pins(4'h0);
      sleep_low <= 1'b1;
      wait_cyc(8);
      rd_chk(OFF_STATUS, 32'h0);
      open_pu <= 2'h0;
      open_pd <= 2'h0;
      ol_run(32'h0, len_s);
      rd_chk(OFF_STATUS, 32'h0);
      check_word(32'(len_l - len_s), 32'(2 * (LONG - SHORT)));
      $display("test open load done");
      open_pu <= 2'h3;
      open_pd <= 2'h3;
      dis_pin <= 1'b1;
      wait_cyc(4);
      apb(1'b1, OFF_CTRL, 32'h2);
      wait_cyc(2);
      dis_pin <= 1'b0;
      wait_cyc(40);
      rd_chk(OFF_CTRL, 32'h0);
      rd_chk(OFF_STATUS, 32'h0);
      check_pins(4'hE);
      energ   <= 1'b1;
      dis_pin <= 1'b1;
      wait_cyc(6);
      apb(1'b1, OFF_CTRL, 32'h2);
      rd_chk(OFF_CTRL, 32'h0);
      wait_cyc(40);
      rd_chk(OFF_STATUS, 32'h0);
      $display("test abort done");
      complete_run();
   end
endmodule : mdfp_top_tb_top
